// ===== io_field_decode.sv
/*
 Decoder for one 4-bit I/O-control field in the restricted mode.
 Assumes a field taken from a register on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module io_field_decode #(
   parameter bit CAPTURE_OK = 1'b1
) (
   input  wire logic [3:0]             field,
   output var timer_io_pkg::io_fn_t    fn
);
   always_comb begin
      if (field == 4'h0) begin
         fn = timer_io_pkg::FN_COMPARE;
      end else if (CAPTURE_OK && field[3:2] == 2'b11) begin
         fn = timer_io_pkg::FN_CAPTURE;
      end else begin
         fn = timer_io_pkg::FN_BAD;
      end
   end
endmodule // io_field_decode
`default_nettype wire

// ===== timer_io_checks_properties.sv
/* Capture-strobe checker for timer_io_select.
   Assumes single-cycle event pulses on mclk. */
`timescale 1ns/1ns
`default_nettype none
module timer_io_checks (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ch1_count_up,
   input wire logic ch1_count_down,
   input wire logic ch0_a_compare_match,
   input wire logic ch0_a_input_capture,
   input wire logic ch0_a_capture_strobe,
   input wire logic ch0_c_capture_strobe,
   input wire logic ch1_a_capture_strobe,
   input wire logic ch0_a_is_capture,
   input wire logic ch0_c_is_capture,
   input wire logic ch1_a_is_capture
);
   wire count_ev = ch1_count_up | ch1_count_down;
   wire match_ev = ch0_a_compare_match | ch0_a_input_capture;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_ch0a_load: assert property (
      count_ev |=> ch0_a_capture_strobe == $past(ch0_a_is_capture)) else $error("ch0 A load");
   a_ch0_quiet: assert property (
      !count_ev |=> !ch0_a_capture_strobe && !ch0_c_capture_strobe) else $error("stray ch0");
   a_ch0c_sel: assert property (
      ch0_c_capture_strobe |-> $past(ch0_c_is_capture && count_ev)) else $error("ch0 C load");
   a_ch1a_load: assert property (
      match_ev |=> ch1_a_capture_strobe == $past(ch1_a_is_capture)) else $error("ch1 A load");
   a_ch1_quiet: assert property (
      !match_ev |=> !ch1_a_capture_strobe) else $error("stray ch1");
   a_ch0a_cause: assert property (
      ch0_a_capture_strobe |-> $past(ch0_a_is_capture)) else $error("ch0 A cause");
   c_ch0a: cover property (ch0_a_capture_strobe);
   c_ch0c: cover property (ch0_c_capture_strobe);
   c_ch1a: cover property (ch1_a_capture_strobe);
endmodule // timer_io_checks
bind timer_io_select timer_io_checks i_timer_io_checks (.*);
`default_nettype wire

// ===== timer_io_defs.svh
/*
 Register offsets, field positions and reset values for the timer I/O select block.
 Assumes inclusion by bare name from design files.
*/
`ifndef TIMER_IO_DEFS_SVH
`define TIMER_IO_DEFS_SVH
`define OFS_CH0_IO_HIGH   4'h0
`define OFS_CH0_IO_LOW    4'h4
`define OFS_CH1_IO        4'h8
`define OFS_CH2_IO        4'hC
`define OFS_CH0_MODE      5'h10
`define OFS_STATUS        5'h14
`define BUF_A_BIT         4
`define IO_RESET          8'h00
`define MODE_RESET        8'h00
`endif

// ===== timer_io_pkg.sv
/*
 Types for the timer I/O select block.
 Assumes nothing of its surroundings.
*/
package timer_io_pkg;
   typedef enum logic [1:0] {
      FN_COMPARE = 2'b00,
      FN_CAPTURE = 2'b01,
      FN_BAD     = 2'b10
   } io_fn_t;
endpackage

// ===== timer_io_select.sv
/*
 I/O select for timer channels 0 to 2: register file on classic Wishbone,
 field decode and internal capture strobes.
 Assumes count and compare events are one-cycle pulses on mclk.
*/
// Chosen here: the address map and the Wishbone register port.
// Summary of operation
// - Ch0 A/C: 0000 compare, 11xx capture
// - Ch0 captures on ch1 count up/down
// - Buffer mode A blocks register C capture
// - Ch1 A: 0000 compare, 11xx capture
// - Ch1 A captures on ch0 A events
`timescale 1ns/1ns
`default_nettype none
`include "timer_io_defs.svh"
module timer_io_select (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ch1_count_up,
   input  wire logic        ch1_count_down,
   input  wire logic        ch0_a_compare_match,
   input  wire logic        ch0_a_input_capture,
   output logic             ch0_a_capture_strobe,
   output logic             ch0_c_capture_strobe,
   output logic             ch1_a_capture_strobe,
   output logic             ch0_a_is_capture,
   output logic             ch0_c_is_capture,
   output logic             ch1_a_is_capture,
   output logic             setting_error
);
   // Register file
   logic [7:0]           io0h_q;
   logic [7:0]           io0h_d;
   logic [7:0]           io0l_q;
   logic [7:0]           io0l_d;
   logic [7:0]           io1_q;
   logic [7:0]           io1_d;
   logic [7:0]           io2_q;
   logic [7:0]           io2_d;
   logic [7:0]           mode_q;
   logic [7:0]           mode_d;
   // Bus answer
   logic                 ack_q;
   logic                 ack_d;
   logic [31:0]          rd_q;
   logic [31:0]          rd_d;
   // Capture strobes
   logic                 s0a_q;
   logic                 s0a_d;
   logic                 s0c_q;
   logic                 s0c_d;
   logic                 s1a_q;
   logic                 s1a_d;
   // Bus decode
   logic                 req;
   logic                 wr_req;
   logic                 rd_req;
   logic                 hit_io0h;
   logic                 hit_io0l;
   logic                 hit_io1;
   logic                 hit_io2;
   logic                 hit_mode;
   logic                 hit_status;
   logic [5:0]           status;
   timer_io_pkg::io_fn_t fn0a;
   timer_io_pkg::io_fn_t fn0c;
   timer_io_pkg::io_fn_t fn1a;
   timer_io_pkg::io_fn_t fn2a;

   io_field_decode #(
      .CAPTURE_OK(1'b1)
   ) u_dec0a (
      .field(io0h_q[3:0]),
      .fn   (fn0a)
   );
   io_field_decode #(
      .CAPTURE_OK(1'b1)
   ) u_dec0c (
      .field(io0l_q[3:0]),
      .fn   (fn0c)
   );
   io_field_decode #(
      .CAPTURE_OK(1'b1)
   ) u_dec1a (
      .field(io1_q[3:0]),
      .fn   (fn1a)
   );
   // No capture source exists for channel 2
   io_field_decode #(
      .CAPTURE_OK(1'b0)
   ) u_dec2a (
      .field(io2_q[3:0]),
      .fn   (fn2a)
   );

   // A request is taken once; the pending ack masks the held strobe
   assign req        = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_req     = req && wb_we_i && wb_sel_i[0];
   assign rd_req     = req && !wb_we_i;
   assign hit_io0h   = wb_adr_i == {1'b0, `OFS_CH0_IO_HIGH};
   assign hit_io0l   = wb_adr_i == {1'b0, `OFS_CH0_IO_LOW};
   assign hit_io1    = wb_adr_i == {1'b0, `OFS_CH1_IO};
   assign hit_io2    = wb_adr_i == {1'b0, `OFS_CH2_IO};
   assign hit_mode   = wb_adr_i == `OFS_CH0_MODE;
   assign hit_status = wb_adr_i == `OFS_STATUS;

   assign status = {ch0_a_is_capture,
                    ch0_c_is_capture,
                    ch1_a_is_capture,
                    fn0a == timer_io_pkg::FN_BAD,
                    fn0c == timer_io_pkg::FN_BAD,
                    setting_error};

   always_comb begin
      io0h_d = io0h_q;
      io0l_d = io0l_q;
      io1_d  = io1_q;
      io2_d  = io2_q;
      mode_d = mode_q;
      // Only the low byte lane carries a register
      if (wr_req && hit_io0h) begin
         io0h_d = wb_dat_i[7:0];
      end
      if (wr_req && hit_io0l) begin
         io0l_d = wb_dat_i[7:0];
      end
      if (wr_req && hit_io1) begin
         io1_d = wb_dat_i[7:0];
      end
      if (wr_req && hit_io2) begin
         io2_d = wb_dat_i[7:0];
      end
      if (wr_req && hit_mode) begin
         mode_d = wb_dat_i[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         io0h_q <= `IO_RESET;
         io0l_q <= `IO_RESET;
         io1_q  <= `IO_RESET;
         io2_q  <= `IO_RESET;
         mode_q <= `MODE_RESET;
      end else begin
         io0h_q <= io0h_d;
         io0l_q <= io0l_d;
         io1_q  <= io1_d;
         io2_q  <= io2_d;
         mode_q <= mode_d;
      end
   end

   // Read data is held until the next read, so a slow master still sees it
   always_comb begin
      ack_d = req;
      rd_d  = rd_q;
      if (rd_req) begin
         if (hit_io0h) begin
            rd_d = {24'h000000, io0h_q};
         end else if (hit_io0l) begin
            rd_d = {24'h000000, io0l_q};
         end else if (hit_io1) begin
            rd_d = {24'h000000, io1_q};
         end else if (hit_io2) begin
            rd_d = {24'h000000, io2_q};
         end else if (hit_mode) begin
            rd_d = {24'h000000, mode_q};
         end else if (hit_status) begin
            rd_d = {26'h0, status};
         end else begin
            rd_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rd_q  <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         rd_q  <= rd_d;
      end
   end

   always_comb begin
      ch0_a_is_capture = fn0a == timer_io_pkg::FN_CAPTURE;
      // Buffer use of C overrides its own capture selection
      ch0_c_is_capture = fn0c == timer_io_pkg::FN_CAPTURE
                         && !mode_q[`BUF_A_BIT];
      ch1_a_is_capture = fn1a == timer_io_pkg::FN_CAPTURE;
      // A prohibited code drives no capture and sets setting_error instead, except in C while buffer mode A is set
      setting_error = fn0a == timer_io_pkg::FN_BAD || fn1a == timer_io_pkg::FN_BAD
                      || fn2a == timer_io_pkg::FN_BAD
                      || (fn0c == timer_io_pkg::FN_BAD && !mode_q[`BUF_A_BIT]);
      s0a_d = ch0_a_is_capture && (ch1_count_up || ch1_count_down);
      s0c_d = ch0_c_is_capture && (ch1_count_up || ch1_count_down);
      s1a_d = ch1_a_is_capture
              && (ch0_a_compare_match || ch0_a_input_capture);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s0a_q <= 1'b0;
         s0c_q <= 1'b0;
         s1a_q <= 1'b0;
      end else begin
         s0a_q <= s0a_d;
         s0c_q <= s0c_d;
         s1a_q <= s1a_d;
      end
   end

   assign ch0_a_capture_strobe = s0a_q;
   assign ch0_c_capture_strobe = s0c_q;
   assign ch1_a_capture_strobe = s1a_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_q;
endmodule // timer_io_select
`default_nettype wire

// ===== timer_io_select_tb_top.sv
/* Testbench for timer_io_select: codes, capture strobes, buffer mode.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module timer_io_select_tb_top;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        req = 1'b0;
   logic        we = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0]  ev = 4'h0;
   logic [31:0] q;
   logic [31:0] rdat;
   logic        ack;
   logic [2:0]  stb;
   logic [5:0]  s;
   logic        cap;
   logic        bad;
   logic [2:0]  sel_cap;
   logic        set_err;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   always #5 mclk = ~mclk;
   timer_io_select i_timer_io_select (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ch1_count_up(ev[0]), .ch1_count_down(ev[1]), .ch0_a_compare_match(ev[2]),
      .ch0_a_input_capture(ev[3]), .ch0_a_capture_strobe(stb[2]), .ch0_c_capture_strobe(stb[1]),
      .ch1_a_capture_strobe(stb[0]), .ch0_a_is_capture(sel_cap[2]),
      .ch0_c_is_capture(sel_cap[1]), .ch1_a_is_capture(sel_cap[0]),
      .setting_error(set_err));
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
      samples_checked++;
      if (v !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, v, e);
      end
   endtask
   // Request held until the edge that samples ack
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] r);
      @(posedge mclk);
      {req, we, adr, dat} <= {1'b1, w, a, 24'h0, d};
      // The wait ends once ack is seen high, or at the watchdog
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      r = rdat;
      req <= 1'b0;
   endtask
   task automatic pulse(input logic [3:0] e, input logic [2:0] x);
      @(posedge mclk);
      ev <= e;
      @(posedge mclk);
      ev <= 4'h0;
      #1;
      chk({29'h0, stb}, {29'h0, x});
   endtask
   task automatic stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      for (int r = 0; r < 7; r++) begin
         bus(5'(r * 4), 1'b0, 8'h00, q);
         chk(q, 32'h0);
      end
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 16; c++) begin
            if (r == 3 && c != 0) break;
            cap = c[3:2] == 2'b11 && r != 3;
            bad = c != 0 && !cap;
            s = {r == 0 && cap, r == 1 && cap, r == 2 && cap, r == 0 && bad, r == 1 && bad, bad};
            bus(5'(r * 4), 1'b1, {4'hA, 4'(c)}, q);
            bus(5'(r * 4), 1'b0, 8'h00, q);
            chk(q, {24'h0, 4'hA, 4'(c)});
            bus(5'h14, 1'b0, 8'h00, q);
            chk(q, {26'h0, s});
            chk({28'h0, sel_cap, set_err}, {28'h0, s[5:3], s[0]});
            bus(5'(r * 4), 1'b1, 8'h00, q);
         end
      end
      bus(5'h00, 1'b1, 8'h0C, q);
      bus(5'h04, 1'b1, 8'h0F, q);
      bus(5'h08, 1'b1, 8'h0E, q);
      pulse(4'h2, 3'b110);
      pulse(4'h4, 3'b001);
      pulse(4'h8, 3'b001);
      bus(5'h10, 1'b1, 8'h10, q);
      pulse(4'h1, 3'b100);
      bus(5'h00, 1'b1, 8'h00, q);
      pulse(4'h3, 3'b000);
      bus(5'h08, 1'b1, 8'h00, q);
      pulse(4'hC, 3'b000);
      stop_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end
endmodule // timer_io_select_tb_top
`default_nettype wire
